// [src/aalc_lock_classifier.sv]
// Locked access classifier: cacheable lock versus bus lock
`timescale 1ns/1ps
`default_nettype none
module aalc_lock_classifier #(
   parameter int ADDR_W          = 48,
   parameter int LINE_BYTES      = aalc_pkg::LINE_BYTES,
   parameter int LOCK_ALIGN_LOG2 = 6,
   parameter int LOCK_WIN_CYC    = aalc_pkg::LOCK_WIN_CYC
) (
   // Clock, reset, enable
   input  wire logic                              clk,
   input  wire logic                              sys_rst,
   input  wire logic                              ce,
   // Access request
   input  wire logic                              req_valid,
   input  wire logic [ADDR_W-1:0]                 req_addr,
   input  wire logic [aalc_pkg::SIZE_W-1:0]       req_size_log2,
   input  wire aalc_pkg::aalc_mtype_e             req_mtype,
   input  wire aalc_pkg::aalc_kind_e              req_kind,
   input  wire logic                              req_locked,
   output logic                                   req_ready,
   // Configuration
   input  wire logic                              cfg_wide_vec,
   input  wire logic [aalc_pkg::LIMIT_W-1:0]      cfg_lock_limit,
   // Memory access pipeline
   output logic                                   access_go,
   input  wire logic                              access_done,
   // Decision
   output logic                                   dec_valid,
   output logic                                   dec_bus_lock,
   output logic                                   dec_atomic,
   output logic                                   dec_split,
   output logic                                   line_hold,
   // System bus lock handshake
   output logic                                   bus_lock_req,
   input  wire logic                              bus_lock_gnt,
   // Bus lock reporting
   output logic                                   bus_lock_event,
   output logic                                   bus_lock_throttle,
   output logic [aalc_pkg::COUNT_W-1:0]           bus_lock_count,
   // Identification words
   output logic [aalc_pkg::ID_W-1:0]              id_feature_word,
   output logic [aalc_pkg::ID_W-1:0]              id_l1d_word
);
   localparam int LINE_LOG2 = $clog2(LINE_BYTES);

   if ((1 << LINE_LOG2) != LINE_BYTES || LINE_BYTES >= (1 << aalc_pkg::LINE_FIELD_W) ||
       LINE_BYTES < (1 << aalc_pkg::DQWORD_LOG2)) begin : g_bad_line
      $error("LINE_BYTES must be a power of two from 16 to 128");
   end
   if (LOCK_ALIGN_LOG2 < aalc_pkg::QWORD_LOG2 || LOCK_ALIGN_LOG2 > LINE_LOG2) begin : g_bad_al
      $error("LOCK_ALIGN_LOG2 must lie between quadword and line size");
   end
   if (ADDR_W < aalc_pkg::OFF_W || LOCK_WIN_CYC < 2) begin : g_bad_misc
      $error("ADDR_W or LOCK_WIN_CYC too small");
   end

   // True when the access runs past a 2**blog2 byte boundary
   function automatic logic crosses(input logic [ADDR_W-1:0]           a,
                                    input logic [aalc_pkg::SIZE_W-1:0] sz,
                                    input int unsigned                 blog2);
      logic [aalc_pkg::OFF_W-1:0] off;
      logic [aalc_pkg::OFF_W-1:0] last;
      off  = a[aalc_pkg::OFF_W-1:0] & aalc_pkg::OFF_W'((32'h1 << blog2) - 32'h1);
      last = off + aalc_pkg::OFF_W'((32'h1 << sz) - 32'h1);
      return (last >> blog2) != '0;
   endfunction

   // True when the address is a multiple of the access size
   function automatic logic aligned(input logic [ADDR_W-1:0]           a,
                                    input logic [aalc_pkg::SIZE_W-1:0] sz);
      return (a[aalc_pkg::OFF_W-1:0] &
              aalc_pkg::OFF_W'((32'h1 << sz) - 32'h1)) == '0;
   endfunction

   aalc_pkg::aalc_state_e         state_q;
   logic                          ready_q;
   logic                          go_pend_q;
   logic                          go_q;
   logic [ADDR_W-1:0]             addr_q;
   logic [aalc_pkg::SIZE_W-1:0]   size_q;
   aalc_pkg::aalc_mtype_e         mtype_q;
   logic                          locked_q;
   logic                          wide_q;
   logic                          gnt_s1_q;
   logic                          gnt_s2_q;
   logic                          dec_valid_q;
   logic                          dec_bus_q;
   logic                          dec_atomic_q;
   logic                          dec_split_q;
   logic                          line_hold_q;
   logic                          bus_req_q;
   logic                          event_q;
   logic [aalc_pkg::ID_W-1:0]     id_feat_q;
   logic [aalc_pkg::ID_W-1:0]     id_l1d_q;

   logic                          take_w;
   logic                          lk_w;
   logic                          cacheable_w;
   logic                          nat_w;
   logic                          in_qw_w;
   logic                          atomic_w;
   logic                          non_wrbk_w;
   logic                          misal_w;
   logic                          line_x_w;
   logic                          oversize_w;
   logic                          bus_w;
   logic                          done_w;
   logic                          grant_w;

   aalc_lim_if lim_if ();

   aalc_lock_limiter #(
      .WIN_CYC (LOCK_WIN_CYC)
   ) u_lim (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .lim     (lim_if.lim)
   );

   // Limiter counts granted locks and throttles new lock requests
   assign lim_if.event_p = event_q;
   assign lim_if.limit   = cfg_lock_limit;

   assign take_w  = state_q == aalc_pkg::ST_IDLE && req_valid && ready_q;
   assign done_w  = state_q == aalc_pkg::ST_ACCESS && !go_pend_q && access_done;
   // A grant counts only while our own request stands
   assign grant_w = state_q == aalc_pkg::ST_LOCK_REQ && bus_req_q && gnt_s2_q;

   // System operations are implicitly locked
   always_comb begin
      unique case (req_kind)
         aalc_pkg::K_PLAIN:     lk_w = req_locked;
         aalc_pkg::K_SW_ATOMIC: lk_w = 1'b1;
         aalc_pkg::K_SEG_ACC:   lk_w = 1'b1;
         aalc_pkg::K_GATE_ACC:  lk_w = 1'b1;
         // Flag updates of a walk are not compared with in-flight prefetches
         aalc_pkg::K_PAGE_AD:   lk_w = 1'b1;
         default:               lk_w = 1'b1;
      endcase
   end

   // Single-access atomicity
   assign cacheable_w = mtype_q inside {aalc_pkg::MT_WP, aalc_pkg::MT_WT,
                                        aalc_pkg::MT_WRITEBACK};
   assign nat_w = aligned(addr_q, size_q) &&
                  (size_q <= aalc_pkg::SIZE_W'(aalc_pkg::QWORD_LOG2) ||
                   (wide_q && size_q <= aalc_pkg::SIZE_W'(aalc_pkg::DQWORD_LOG2)));
   assign in_qw_w = size_q < aalc_pkg::SIZE_W'(aalc_pkg::QWORD_LOG2) &&
                    !crosses(addr_q, size_q, aalc_pkg::QWORD_LOG2);
   assign atomic_w = locked_q || (cacheable_w && (nat_w || in_qw_w));

   // Lock classification
   assign non_wrbk_w = mtype_q != aalc_pkg::MT_WRITEBACK;
   assign misal_w    = crosses(addr_q, size_q, LOCK_ALIGN_LOG2);
   assign line_x_w   = crosses(addr_q, size_q, LINE_LOG2);
   assign oversize_w = size_q > aalc_pkg::SIZE_W'(aalc_pkg::DQWORD_LOG2);
   assign bus_w = locked_q && (non_wrbk_w || misal_w || line_x_w || oversize_w);

   // Grant pin synchroniser
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gnt_s1_q <= 1'b0;
         gnt_s2_q <= 1'b0;
      end else if (ce) begin
         gnt_s1_q <= bus_lock_gnt;
         gnt_s2_q <= gnt_s1_q;
      end
   end

   // Sequencer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q   <= aalc_pkg::ST_IDLE;
         ready_q   <= 1'b1;
         go_pend_q <= 1'b0;
      end else if (ce) begin
         unique case (state_q)
            aalc_pkg::ST_IDLE: begin
               if (take_w) begin
                  state_q <= aalc_pkg::ST_DECIDE;
                  ready_q <= 1'b0;
               end
            end
            aalc_pkg::ST_DECIDE: begin
               if (bus_w) begin
                  state_q <= aalc_pkg::ST_LOCK_REQ;
               end else begin
                  state_q   <= aalc_pkg::ST_ACCESS;
                  go_pend_q <= 1'b1;
               end
            end
            aalc_pkg::ST_LOCK_REQ: begin
               if (grant_w) begin
                  state_q   <= aalc_pkg::ST_ACCESS;
                  go_pend_q <= 1'b1;
               end
            end
            aalc_pkg::ST_ACCESS: begin
               if (go_pend_q) begin
                  go_pend_q <= 1'b0;
               end else if (access_done) begin
                  state_q <= aalc_pkg::ST_IDLE;
                  ready_q <= 1'b1;
               end
            end
            default: begin
               state_q   <= aalc_pkg::ST_IDLE;
               ready_q   <= 1'b1;
               go_pend_q <= 1'b0;
            end
         endcase
      end
   end

   // Request capture
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         addr_q   <= '0;
         size_q   <= '0;
         mtype_q  <= aalc_pkg::MT_UC;
         locked_q <= 1'b0;
      end else if (ce && take_w) begin
         addr_q   <= req_addr;
         size_q   <= req_size_log2;
         mtype_q  <= req_mtype;
         locked_q <= lk_w;
      end
   end

   // Start pulse for the memory access
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         go_q <= 1'b0;
      end else if (ce) begin
         go_q <= state_q == aalc_pkg::ST_ACCESS && go_pend_q;
      end
   end

   // One decision per operation, issued a cycle ahead of the start pulse of a local access, earlier for a bus lock
   // Fields stay until the next decision so a slow reader still sees them
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dec_valid_q  <= 1'b0;
         dec_bus_q    <= 1'b0;
         dec_atomic_q <= 1'b0;
         dec_split_q  <= 1'b0;
      end else if (ce) begin
         dec_valid_q <= state_q == aalc_pkg::ST_DECIDE;
         if (state_q == aalc_pkg::ST_DECIDE) begin
            dec_bus_q    <= bus_w;
            dec_atomic_q <= atomic_w;
            dec_split_q  <= !atomic_w;
         end
      end
   end

   // Cacheable lock keeps the line local until the operation completes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         line_hold_q <= 1'b0;
      end else if (ce) begin
         if (state_q == aalc_pkg::ST_DECIDE && locked_q && !bus_w) begin
            line_hold_q <= 1'b1;
         end else if (done_w) begin
            line_hold_q <= 1'b0;
         end
      end
   end

   // Four-phase system lock handshake, held to completion
   // Waiting for the old grant to fall keeps a late release from reading as a new grant
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus_req_q <= 1'b0;
      end else if (ce) begin
         if (state_q == aalc_pkg::ST_LOCK_REQ && !bus_req_q &&
             !gnt_s2_q && !lim_if.throttle) begin
            bus_req_q <= 1'b1;
         end else if (done_w) begin
            bus_req_q <= 1'b0;
         end
      end
   end

   // One pulse per granted bus lock
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         event_q <= 1'b0;
      end else if (ce) begin
         event_q <= grant_w;
      end
   end

   // Identification words
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wide_q    <= 1'b0;
         id_feat_q <= '0;
         id_l1d_q  <= '0;
      end else if (ce) begin
         wide_q    <= cfg_wide_vec;
         id_feat_q <= aalc_pkg::ID_W'(cfg_wide_vec) << aalc_pkg::WIDE_VEC_BIT;
         id_l1d_q  <= aalc_pkg::ID_W'(aalc_pkg::LINE_FIELD_W'(LINE_BYTES));
      end
   end

   assign req_ready         = ready_q;
   assign access_go         = go_q;
   assign dec_valid         = dec_valid_q;
   assign dec_bus_lock      = dec_bus_q;
   assign dec_atomic        = dec_atomic_q;
   assign dec_split         = dec_split_q;
   assign line_hold         = line_hold_q;
   assign bus_lock_req      = bus_req_q;
   assign bus_lock_event    = event_q;
   assign bus_lock_throttle = lim_if.throttle;
   assign bus_lock_count    = lim_if.total;
   assign id_feature_word   = id_feat_q;
   assign id_l1d_word       = id_l1d_q;
endmodule
`default_nettype wire

// [src/aalc_pkg.sv]
// Shared types and constants of the atomic access lock classifier
package aalc_pkg;

   // Memory types presented with each access
   typedef enum logic [2:0] {
      MT_UC  = 3'h0,
      MT_CD  = 3'h1,
      MT_WC  = 3'h2,
      MT_WCP = 3'h3,
      MT_WP  = 3'h4,
      MT_WT  = 3'h5,
      MT_WRITEBACK = 3'h6
   } aalc_mtype_e;

   // What the access is done on behalf of
   typedef enum logic [2:0] {
      K_PLAIN     = 3'h0,
      K_SW_ATOMIC = 3'h1,
      K_SEG_ACC   = 3'h2,
      K_GATE_ACC  = 3'h3,
      K_PAGE_AD   = 3'h4
   } aalc_kind_e;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'h1,
      ST_DECIDE   = 4'h2,
      ST_LOCK_REQ = 4'h4,
      ST_ACCESS   = 4'h8
   } aalc_state_e;

   localparam int SIZE_W       = 3;
   localparam int QWORD_LOG2   = 3;
   localparam int DQWORD_LOG2  = 4;
   localparam int OFF_W        = 16;
   localparam int WIDE_VEC_BIT = 28;
   localparam int ID_W         = 32;
   localparam int LINE_FIELD_W = 8;
   localparam int LINE_BYTES   = 64;
   localparam int LIMIT_W      = 8;
   localparam int COUNT_W      = 16;
   localparam int CLK_MHZ      = 50;
   localparam int LOCK_WIN_US  = 100;
   localparam int LOCK_WIN_CYC = LOCK_WIN_US * CLK_MHZ;

endpackage

// [src/aalc_lim_if.sv]
// Carrier between the classifier and its bus lock limiter
`timescale 1ns/1ps
`default_nettype none
interface aalc_lim_if;
   logic                          event_p;
   logic [aalc_pkg::LIMIT_W-1:0]  limit;
   logic                          throttle;
   logic [aalc_pkg::COUNT_W-1:0]  total;

   modport ctl (output event_p, output limit, input throttle, input total);
   modport lim (input event_p, input limit, output throttle, output total);
endinterface
`default_nettype wire

// [src/aalc_lock_limiter.sv]
// Bus lock counter and rate limiter
`timescale 1ns/1ps
`default_nettype none
module aalc_lock_limiter #(
   parameter int WIN_CYC = aalc_pkg::LOCK_WIN_CYC
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Link to the classifier
   aalc_lim_if.lim  lim
);
   localparam int CW = $clog2(WIN_CYC);

   logic [CW-1:0]                 win_q;
   logic                          wrap_w;
   logic [aalc_pkg::LIMIT_W-1:0]  cnt_q;
   logic [aalc_pkg::COUNT_W-1:0]  total_q;
   logic                          throttle_q;

   assign wrap_w = win_q == CW'(WIN_CYC - 1);

   // Window timer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         win_q <= '0;
      end else if (ce) begin
         win_q <= wrap_w ? '0 : win_q + 1'b1;
      end
   end

   // Locks seen in the current window
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
      end else if (ce) begin
         if (wrap_w) begin
            cnt_q <= lim.event_p ? aalc_pkg::LIMIT_W'(1) : '0;
         end else if (lim.event_p && cnt_q != '1) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // Throttle while the window quota is used up; zero limit disables
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         throttle_q <= 1'b0;
      end else if (ce) begin
         throttle_q <= !wrap_w && lim.limit != '0 && cnt_q >= lim.limit;
      end
   end

   // Saturating total for software reporting
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         total_q <= '0;
      end else if (ce && lim.event_p && total_q != '1) begin
         total_q <= total_q + 1'b1;
      end
   end

   assign lim.throttle = throttle_q;
   assign lim.total    = total_q;
endmodule
`default_nettype wire

// [dv/aalc_lock_checker.sv]
// Concurrent checks on the lock classifier's ports
`timescale 1ns/1ps
`default_nettype none
module aalc_lock_checker #(
   parameter int ADDR_W          = 48,
   parameter int LINE_BYTES      = 64,
   parameter int LOCK_ALIGN_LOG2 = 6
) (
   // Clock and control
   input wire logic                  clk,
   input wire logic                  sys_rst,
   input wire logic                  ce,
   // Request
   input wire logic                  req_valid,
   input wire logic [ADDR_W-1:0]     req_addr,
   input wire logic [2:0]            req_size_log2,
   input wire aalc_pkg::aalc_mtype_e req_mtype,
   input wire aalc_pkg::aalc_kind_e  req_kind,
   input wire logic                  req_locked,
   input wire logic                  req_ready,
   input wire logic                  cfg_wide_vec,
   // Access and decision
   input wire logic                  access_go,
   input wire logic                  access_done,
   input wire logic                  dec_valid,
   input wire logic                  dec_bus_lock,
   input wire logic                  dec_atomic,
   input wire logic                  dec_split,
   input wire logic                  line_hold,
   // Bus lock and identification
   input wire logic                  bus_lock_req,
   input wire logic                  bus_lock_event,
   input wire logic                  bus_lock_throttle,
   input wire logic [31:0]           id_feature_word,
   input wire logic [31:0]           id_l1d_word
);
   logic [15:0] a_q;
   logic [2:0]  s_q;
   logic        lk_q, wrbk_q, cac_q, wide_q;
   logic        exp_bus, exp_at;

   // True when the access runs past a 2**b byte boundary
   function automatic logic crs(input logic [15:0] a, input logic [2:0] s, input int b);
      return 32'(a) % (32'h1 << b) + (32'h1 << s) > (32'h1 << b);
   endfunction

   // Remember the request that was taken
   always_ff @(posedge clk) begin
      if (ce && req_valid && req_ready) begin
         a_q    <= req_addr[15:0];
         s_q    <= req_size_log2;
         lk_q   <= req_kind != aalc_pkg::K_PLAIN || req_locked;
         wrbk_q <= req_mtype == aalc_pkg::MT_WRITEBACK;
         cac_q  <= req_mtype inside {aalc_pkg::MT_WP, aalc_pkg::MT_WT, aalc_pkg::MT_WRITEBACK};
         wide_q <= cfg_wide_vec;
      end
   end

   assign exp_bus = lk_q && (!wrbk_q || s_q > 3'h4 || crs(a_q, s_q, LOCK_ALIGN_LOG2)
                    || crs(a_q, s_q, $clog2(LINE_BYTES)));
   assign exp_at = lk_q || cac_q && (32'(a_q) % (32'h1 << s_q) == 0
                   && (s_q <= 3'h3 || wide_q && s_q == 3'h4)
                   || s_q < 3'h3 && !crs(a_q, s_q, 3));

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_dec_follows: assert property (ce && req_valid && req_ready |-> ##[1:3] dec_valid)
      else $error("no decision after request");
   a_dec_single: assert property (dec_valid |=> !dec_valid)
      else $error("decision longer than one cycle");
   a_bus_class: assert property (dec_valid |-> dec_bus_lock == exp_bus)
      else $error("wrong lock class");
   a_atomic_class: assert property (dec_valid |-> dec_atomic == exp_at && dec_split == !exp_at)
      else $error("wrong atomicity");
   a_local_go: assert property (dec_valid && !dec_bus_lock |=> access_go && !bus_lock_req)
      else $error("local access not started");
   a_line_held: assert property (dec_valid && !dec_bus_lock && lk_q |=> line_hold)
      else $error("line not held");
   a_go_granted: assert property (access_go && dec_bus_lock |-> bus_lock_req)
      else $error("bus locked access without lock");
   a_event_go: assert property (bus_lock_event |=> access_go)
      else $error("no access after lock event");
   a_req_held: assert property (bus_lock_req && !access_done |=> bus_lock_req)
      else $error("bus lock dropped early");
   a_throttle_req: assert property ($rose(bus_lock_req) |-> !$past(bus_lock_throttle))
      else $error("lock raised while throttled");
   a_line_size: assert property (!$past(sys_rst) |-> id_l1d_word == 32'(LINE_BYTES))
      else $error("line size word wrong");
   a_wide_flag: assert property (!$past(sys_rst) && $past(ce) |-> id_feature_word[28] == $past(cfg_wide_vec))
      else $error("wide flag wrong");
endmodule

bind aalc_lock_classifier aalc_lock_checker #(.ADDR_W(ADDR_W), .LINE_BYTES(LINE_BYTES),
   .LOCK_ALIGN_LOG2(LOCK_ALIGN_LOG2)) aalc_lock_checker_inst (
   .clk, .sys_rst, .ce, .req_valid, .req_addr, .req_size_log2, .req_mtype, .req_kind,
   .req_locked, .req_ready, .cfg_wide_vec, .access_go, .access_done, .dec_valid,
   .dec_bus_lock, .dec_atomic, .dec_split, .line_hold, .bus_lock_req, .bus_lock_event,
   .bus_lock_throttle, .id_feature_word, .id_l1d_word
);
`default_nettype wire

// [dv/aalc_far_side.sv]
// Model of the other masters: grants bus locks and completes accesses
`timescale 1ns/1ps
`default_nettype none
module aalc_far_side (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // High answers slowly
   input wire logic slow,
   // Lock handshake
   input wire logic bus_lock_req,
   output logic     bus_lock_gnt,
   // Memory access
   input wire logic access_go,
   output logic     access_done
);
   int gnt_wait;
   int busy;

   // Grant once the others have stalled; release follows the request
   always_ff @(posedge clk) begin
      if (sys_rst || !bus_lock_req) begin
         bus_lock_gnt <= 1'b0;
         gnt_wait     <= 0;
      end else if (gnt_wait >= (slow ? 6 : 1)) begin
         bus_lock_gnt <= 1'b1;
      end else begin
         gnt_wait <= gnt_wait + 1;
      end
   end

   // One-cycle completion some cycles after the start
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         access_done <= 1'b0;
         busy        <= 0;
      end else begin
         access_done <= busy == 1;
         busy        <= access_go ? (slow ? 5 : 2) : (busy > 0 ? busy - 1 : 0);
      end
   end
endmodule
`default_nettype wire

// [dv/tb_aalc_lock_classifier.sv]
// Self-checking bench of the lock classifier
`timescale 1ns/1ps
`default_nettype none
module tb_aalc_lock_classifier;
   logic                  clk            = 1'b0;
   logic                  sys_rst        = 1'b1;
   logic                  ce             = 1'b1;
   logic                  req_valid      = 1'b0;
   logic [47:0]           req_addr       = 48'h0;
   logic [2:0]            req_size_log2  = 3'h0;
   aalc_pkg::aalc_mtype_e req_mtype      = aalc_pkg::MT_WRITEBACK;
   aalc_pkg::aalc_kind_e  req_kind       = aalc_pkg::K_PLAIN;
   logic                  req_locked     = 1'b0;
   logic                  cfg_wide_vec   = 1'b0;
   logic [7:0]            cfg_lock_limit = 8'h0;
   logic                  slow           = 1'b0;
   int                    thr_cnt        = 0;
   logic                  req_ready, access_go, access_done, dec_valid, dec_bus_lock;
   logic                  dec_atomic, dec_split, line_hold, bus_lock_req, bus_lock_gnt;
   logic                  bus_lock_event, bus_lock_throttle;
   logic [15:0]           bus_lock_count;
   logic [31:0]           id_feature_word, id_l1d_word;
   int                    fails          = 0;
   int                    checks_done    = 0;

   aalc_lock_classifier #(.LOCK_WIN_CYC(20)) aalc_lock_classifier_inst (
      .clk, .sys_rst, .ce, .req_valid, .req_addr, .req_size_log2, .req_mtype, .req_kind,
      .req_locked, .req_ready, .cfg_wide_vec, .cfg_lock_limit, .access_go, .access_done,
      .dec_valid, .dec_bus_lock, .dec_atomic, .dec_split, .line_hold, .bus_lock_req,
      .bus_lock_gnt, .bus_lock_event, .bus_lock_throttle, .bus_lock_count,
      .id_feature_word, .id_l1d_word
   );
   aalc_far_side aalc_far_side_inst (
      .clk, .sys_rst, .slow, .bus_lock_req, .bus_lock_gnt, .access_go, .access_done
   );

   always #10 clk = ~clk;
   always @(posedge clk) if (bus_lock_throttle === 1'b1) thr_cnt <= thr_cnt + 1;

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 300) begin
         tick();
         n++;
      end
      if (n >= 300) begin
         chk(req_ready, 1'b1);
         summarize();
      end
   endtask

   // One whole operation; codes are memory type and kind encodings
   task automatic op(input logic [47:0] a, input logic [2:0] s, input logic [2:0] m,
                     input logic [2:0] k, input logic l, input logic eb, input logic ea);
      int n;
      wait_ready();
      req_addr      = a;
      req_size_log2 = s;
      req_mtype     = aalc_pkg::aalc_mtype_e'(m);
      req_kind      = aalc_pkg::aalc_kind_e'(k);
      req_locked    = l;
      req_valid     = 1'b1;
      tick();
      req_valid = 1'b0;
      n = 0;
      while (dec_valid !== 1'b1 && n < 8) begin
         tick();
         n++;
      end
      chk(dec_valid, 1'b1);
      chk(dec_bus_lock, eb);
      chk(dec_atomic, ea);
      chk(dec_split, !ea);
      wait_ready();
   endtask

   task automatic t_ident();
      chk(id_l1d_word, 32'h00000040);
      chk(id_feature_word[28], 1'b0);
      cfg_wide_vec = 1'b1;
      tick();
      tick();
      chk(id_feature_word[28], 1'b1);
      cfg_wide_vec = 1'b0;
      $display("test ident done");
   endtask

   task automatic t_mtypes();
      for (int i = 0; i < 7; i++) begin
         op(48'h100, 3'h3, 3'(i), 3'h1, 1'b0, i != 6, 1'b1);
      end
      $display("test memory types done");
   endtask

   task automatic t_kinds();
      for (int k = 1; k < 5; k++) begin
         op(48'h208, 3'h3, 3'h6, 3'(k), 1'b0, 1'b0, 1'b1);
      end
      op(48'h208, 3'h3, 3'h6, 3'h5, 1'b0, 1'b0, 1'b1);
      // Walk flag update on the last quadword of a line
      op(48'h1F8, 3'h3, 3'h6, 3'h4, 1'b0, 1'b0, 1'b1);
      $display("test kinds done");
   endtask

   task automatic t_align();
      op(48'h13C, 3'h2, 3'h6, 3'h0, 1'b1, 1'b0, 1'b1);
      op(48'h13C, 3'h3, 3'h6, 3'h0, 1'b1, 1'b1, 1'b1);
      op(48'h3F, 3'h0, 3'h6, 3'h0, 1'b1, 1'b0, 1'b1);
      op(48'h100, 3'h5, 3'h6, 3'h1, 1'b0, 1'b1, 1'b1);
      $display("test alignment done");
   endtask

   task automatic t_plain();
      op(48'h100, 3'h3, 3'h6, 3'h0, 1'b0, 1'b0, 1'b1);
      op(48'h104, 3'h2, 3'h5, 3'h0, 1'b0, 1'b0, 1'b1);
      op(48'h100, 3'h3, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0);
      op(48'h101, 3'h1, 3'h6, 3'h0, 1'b0, 1'b0, 1'b1);
      op(48'h107, 3'h1, 3'h6, 3'h0, 1'b0, 1'b0, 1'b0);
      op(48'h107, 3'h1, 3'h6, 3'h1, 1'b0, 1'b0, 1'b1);
      op(48'h110, 3'h4, 3'h6, 3'h0, 1'b0, 1'b0, 1'b0);
      cfg_wide_vec = 1'b1;
      tick();
      tick();
      op(48'h110, 3'h4, 3'h6, 3'h0, 1'b0, 1'b0, 1'b1);
      op(48'h108, 3'h4, 3'h6, 3'h0, 1'b0, 1'b0, 1'b0);
      cfg_wide_vec = 1'b0;
      $display("test plain done");
   endtask

   task automatic t_throttle();
      logic [15:0] c0;
      int          t0;
      c0 = bus_lock_count;
      t0 = thr_cnt;
      cfg_lock_limit = 8'h01;
      slow = 1'b1;
      op(48'h80, 3'h2, 3'h0, 3'h1, 1'b0, 1'b1, 1'b1);
      op(48'h84, 3'h2, 3'h2, 3'h1, 1'b0, 1'b1, 1'b1);
      chk(thr_cnt > t0, 1'b1);
      chk(bus_lock_count, 32'(c0) + 32'h2);
      cfg_lock_limit = 8'h00;
      slow = 1'b0;
      $display("test throttle done");
   endtask

   // Reset while a bus lock is pending
   task automatic t_rst();
      wait_ready();
      req_mtype  = aalc_pkg::MT_UC;
      req_locked = 1'b1;
      req_valid  = 1'b1;
      tick();
      req_valid = 1'b0;
      repeat (4) tick();
      sys_rst = 1'b1;
      repeat (3) tick();
      chk(req_ready, 1'b1);
      chk(bus_lock_req, 1'b0);
      chk(line_hold, 1'b0);
      sys_rst = 1'b0;
      op(48'h40, 3'h2, 3'h6, 3'h1, 1'b0, 1'b0, 1'b1);
      $display("test reset done");
   endtask

   initial begin
      repeat (5) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      tick();
      t_ident();
      t_mtypes();
      t_kinds();
      t_align();
      t_plain();
      t_throttle();
      t_rst();
      summarize();
   end
endmodule
`default_nettype wire
